// ==== lcs_defines.vh ====
// constants for the lock-clear host sequencer
`ifndef LCS_DEFINES_VH
`define LCS_DEFINES_VH
// software register offsets
`define LCS_REG_CTRL      4'h0
`define LCS_REG_STATUS    4'h1
`define LCS_REG_RESULT    4'h2
`define LCS_REG_CMDCFG    4'h3
// control register bits
`define LCS_CTRL_START    0
`define LCS_CTRL_CLRSTAT  1
`define LCS_CTRL_ARRAY    2
// status bit positions of the device
`define LCS_SR_READY      7
`define LCS_SR_ERASE_SUSP 6
`define LCS_SR_ERASE_ERR  5
`define LCS_SR_PROG_ERR   4
`define LCS_SR_SUPPLY_LOW 3
`define LCS_SR_PROG_SUSP  2
`define LCS_SR_PROTECT    1
`define LCS_SR_MASK       8'hfe
// command codes, both bytes
`define LCS_CMD_CLR_SETUP   16'h6060
`define LCS_CMD_CLR_CONFIRM 16'hd0d0
`define LCS_CMD_CLR_STATUS  16'h5050
`define LCS_CMD_READ_STAT   16'h7070
`define LCS_CMD_READ_ARRAY  16'hffff
// bus phase length in cycles (strobe low time)
`define LCS_PHASE_CYC     4'h8
`endif

// ==== lcs_host.v ====
// host-side sequencer for the lock-bit clear command and status polling
// Operation
// [R1] device unlocks all set blocks together
// [R2] write setup then confirm, back to back
// [R3] device returns status after the sequence
// [R4] done shown on busy pin and ready bit
// [R5] on completion test bit 5, clear on error
// [R6] device stays in status mode until command
// [R7] bad confirm sets bits 4 and 5
// [R8] aborted clear must be reissued
// [R9] bit 7 one when ready
// [R10] bit 6 erase suspended
// [R11] bit 5 erase or clear failed
// [R12] bit 4 program or lock-set failed
// [R13] bit 3 set means issue clear-status
// [R14] bit 2 program suspended
// [R15] bit 1 lock or override abort
// [R16] mask reserved bit 0 when polling
// [R17] ignore bits 6..0 while bit 7 zero
// [R18] bits 5 and 4 mean bad sequence
// [R19] bit 1 sampled only after sequences
// [R20] word status: high and low bytes
// [R21] write ffff to return to array read
// [R22] clear status before any retry
// [R23] error flags stay until clear-status
//
// Chosen here: the plain strobed port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "lcs_defines.vh"
module lcs_host (
    // clock and reset
    input  wire        sys_clk_i,
    input  wire        rst_n_i,
    // software register port
    input  wire [3:0]  reg_addr_i,
    input  wire [15:0] reg_wdata_i,
    input  wire        reg_wr_i,
    input  wire        reg_rd_i,
    output reg  [15:0] reg_rdata_o,
    // card bus
    output reg         card_ce_n_o,
    output reg         card_oe_n_o,
    output reg         card_we_n_o,
    output reg         card_reset_n_o,
    output reg  [15:0] card_data_o,
    output reg         card_data_oe_o,
    input  wire [15:0] card_data_i,
    input  wire        card_busy_n_i
);
    localparam S_IDLE  = 3'd0;
    localparam S_WR    = 3'd1;
    localparam S_GAP   = 3'd2;
    localparam S_RD    = 3'd3;
    localparam S_EVAL  = 3'd4;
    localparam S_DONE  = 3'd5;

    reg [15:0] data_s1_r, data_s2_r;
    reg        busy_s1_r, busy_s2_r;
    reg [2:0]  state_r;
    reg [3:0]  cnt_r;
    reg [1:0]  step_r;        // 0 setup,1 confirm,2 clr-status,3 array
    reg [1:0]  job_r;         // 0 lock clear,1 clear status,2 array read
    reg [15:0] result_r;
    reg        done_r, err_r, seq_err_r, retry_r, active_r;
    reg        was_reset_r;
    wire [15:0] word_st = data_s2_r & {`LCS_SR_MASK, `LCS_SR_MASK};   // R16 R20
    wire        both_rdy = word_st[8+`LCS_SR_READY] & word_st[`LCS_SR_READY];
    wire        any_err;
    genvar g;
    wire [1:0] lane_err;
    generate
        for (g = 0; g < 2; g = g + 1) begin : g_lane
            assign lane_err[g] = word_st[8*g+`LCS_SR_ERASE_ERR] |
                                 word_st[8*g+`LCS_SR_SUPPLY_LOW]; // R5 R13
        end
    endgenerate
    assign any_err = |lane_err;

    always @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            data_s1_r <= 16'h0000;
            data_s2_r <= 16'h0000;
            busy_s1_r <= 1'b0;
            busy_s2_r <= 1'b0;
        end else begin
            data_s1_r <= card_data_i;
            data_s2_r <= data_s1_r;
            busy_s1_r <= card_busy_n_i;
            busy_s2_r <= busy_s1_r;
        end
    end

    always @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            state_r        <= S_IDLE;
            cnt_r          <= 4'h0;
            step_r         <= 2'd0;
            job_r          <= 2'd0;
            result_r       <= 16'h0000;
            done_r         <= 1'b0;
            err_r          <= 1'b0;
            seq_err_r      <= 1'b0;
            retry_r        <= 1'b0;
            active_r       <= 1'b0;
            was_reset_r    <= 1'b1;
            card_ce_n_o    <= 1'b1;
            card_oe_n_o    <= 1'b1;
            card_we_n_o    <= 1'b1;
            card_reset_n_o <= 1'b0;
            card_data_o    <= 16'h0000;
            card_data_oe_o <= 1'b0;
        end else begin
            card_reset_n_o <= 1'b1;
            case (state_r)
                S_IDLE: begin
                    if (reg_wr_i && reg_addr_i == `LCS_REG_CTRL) begin
                        active_r <= 1'b1;
                        done_r   <= 1'b0;
                        if (reg_wdata_i[`LCS_CTRL_START]) begin
                            job_r  <= 2'd0;
                            step_r <= 2'd0;
                            err_r  <= 1'b0;
                            seq_err_r <= 1'b0;
                            was_reset_r <= 1'b0;
                            state_r <= S_WR;
                        end else if (reg_wdata_i[`LCS_CTRL_CLRSTAT]) begin
                            job_r  <= 2'd1;
                            step_r <= 2'd2;
                            state_r <= S_WR;
                        end else if (reg_wdata_i[`LCS_CTRL_ARRAY]) begin
                            job_r  <= 2'd2;
                            step_r <= 2'd3;
                            state_r <= S_WR;
                        end else begin
                            active_r <= 1'b0;
                        end
                    end
                    cnt_r <= 4'h0;
                end
                S_WR: begin
                    card_ce_n_o    <= 1'b0;
                    card_we_n_o    <= 1'b0;
                    card_data_oe_o <= 1'b1;
                    case (step_r)
                        2'd0:    card_data_o <= `LCS_CMD_CLR_SETUP;   // R2
                        2'd1:    card_data_o <= `LCS_CMD_CLR_CONFIRM; // R2
                        2'd2:    card_data_o <= `LCS_CMD_CLR_STATUS;  // R22
                        default: card_data_o <= `LCS_CMD_READ_ARRAY;  // R21
                    endcase
                    cnt_r <= cnt_r + 4'h1;
                    if (cnt_r == `LCS_PHASE_CYC) begin
                        card_we_n_o <= 1'b1;
                        card_ce_n_o <= 1'b1;
                        cnt_r   <= 4'h0;
                        state_r <= S_GAP;
                    end
                end
                S_GAP: begin
                    card_data_oe_o <= 1'b0;
                    cnt_r <= cnt_r + 4'h1;
                    if (cnt_r == `LCS_PHASE_CYC) begin
                        cnt_r <= 4'h0;
                        if (step_r == 2'd0) begin
                            step_r  <= 2'd1;      // confirm follows directly
                            state_r <= S_WR;
                        end else if (job_r == 2'd0) begin
                            state_r <= S_RD;      // device now shows status R3 R6
                        end else begin
                            state_r <= S_DONE;
                        end
                    end
                end
                S_RD: begin
                    card_ce_n_o <= 1'b0;
                    card_oe_n_o <= 1'b0;
                    cnt_r <= cnt_r + 4'h1;
                    // two sync stages plus settle before sampling
                    if (cnt_r == `LCS_PHASE_CYC) begin
                        card_ce_n_o <= 1'b1;
                        card_oe_n_o <= 1'b1;
                        cnt_r   <= 4'h0;
                        state_r <= S_EVAL;
                    end
                end
                S_EVAL: begin
                    // R4 R9 R17: trust low bits only when both lanes ready
                    if (both_rdy && busy_s2_r) begin
                        result_r  <= word_st;
                        err_r     <= any_err;
                        seq_err_r <= word_st[13] & word_st[12] |
                                     word_st[5] & word_st[4];            // R18 R7
                        if (any_err) begin
                            step_r  <= 2'd2;      // clear status, error kept in reg R5 R23
                            job_r   <= 2'd1;
                            retry_r <= 1'b1;
                            state_r <= S_WR;
                        end else begin
                            state_r <= S_DONE;
                        end
                    end else begin
                        state_r <= S_RD;
                    end
                end
                S_DONE: begin
                    done_r   <= 1'b1;
                    active_r <= 1'b0;
                    retry_r  <= 1'b0;
                    state_r  <= S_IDLE;
                end
                default: state_r <= S_IDLE;
            endcase
        end
    end

    // R8: status shows that lock bits are unknown from reset until a clear is started
    always @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            reg_rdata_o <= 16'h0000;
        end else if (reg_rd_i) begin
            case (reg_addr_i)
                `LCS_REG_STATUS: reg_rdata_o <= {11'h000, was_reset_r, seq_err_r,
                                                 err_r, done_r, active_r};
                `LCS_REG_RESULT: reg_rdata_o <= result_r;
                `LCS_REG_CMDCFG: reg_rdata_o <= {14'h0000, retry_r, busy_s2_r};
                default:         reg_rdata_o <= 16'h0000;
            endcase
        end else begin
            reg_rdata_o <= 16'h0000;
        end
    end
endmodule // lcs_host
`default_nettype wire

// ==== lcs_host_asserts.sv ====
// port checker for the lock-clear host sequencer
`timescale 1ns/1ps
`default_nettype none
module lcs_host_chk (
    // clock, reset and register port
    input wire        sys_clk_i,
    input wire        rst_n_i,
    input wire [3:0]  reg_addr_i,
    input wire        reg_rd_i,
    input wire [15:0] reg_rdata_o,
    // card bus
    input wire        card_ce_n_o,
    input wire        card_oe_n_o,
    input wire        card_we_n_o,
    input wire        card_reset_n_o,
    input wire [15:0] card_data_o,
    input wire        card_data_oe_o
);
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!rst_n_i);
    sequence s_cmd(c);
        $fell(card_we_n_o) && card_data_o == c;
    endsequence
    a_setup_then_confirm: assert property (
        s_cmd(16'h6060) |-> ##[9:30] s_cmd(16'hd0d0)) else $error("no confirm");
    a_write_len: assert property (
        $fell(card_we_n_o) |-> !card_we_n_o [*8] ##1 card_we_n_o) else $error("write len");
    a_drive_on_write: assert property (
        !card_we_n_o |-> card_data_oe_o && !card_ce_n_o) else $error("not driven");
    a_no_clash: assert property (card_we_n_o || card_oe_n_o) else $error("clash");
    a_cmd_steady: assert property (
        !card_we_n_o && !$past(card_we_n_o) |-> $stable(card_data_o)) else $error("cmd moved");
    a_cmd_legal: assert property ($fell(card_we_n_o) |-> card_data_o inside
        {16'h6060, 16'hd0d0, 16'h5050, 16'h7070, 16'hffff}) else $error("bad cmd");
    a_poll_after: assert property (
        s_cmd(16'hd0d0) |-> ##[9:40] $fell(card_oe_n_o)) else $error("no poll");
    a_mask_bit0: assert property (reg_rd_i && reg_addr_i == 4'h2 |=>
        !reg_rdata_o[0] && !reg_rdata_o[8]) else $error("bit0 unmasked");
    a_rdata_idle: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 16'h0000)
        else $error("rdata not idle");
    a_card_reset: assert property (disable iff (1'b0) !rst_n_i |=> !card_reset_n_o)
        else $error("card reset");
endmodule // lcs_host_chk
bind lcs_host lcs_host_chk u_chk (.*);
`default_nettype wire

// ==== lcs_card.sv ====
// card model: command decode, engine timing and status word
`timescale 1ns/1ps
`default_nettype none
module lcs_card (
    // host side
    input  wire        clk_i,
    input  wire        ce_n_i,
    input  wire        oe_n_i,
    input  wire        we_n_i,
    input  wire        reset_n_i,
    input  wire [15:0] cmd_i,
    input  wire [1:0]  mode_i,
    // answers
    output wire [15:0] data_o,
    output wire        busy_n_o
);
    reg         we_q = 1'b1, setup = 1'b0, st_mode = 1'b0;
    reg  [7:0]  sr = 8'h00;
    reg  [15:0] last = 16'h0000;
    integer     busy = 0;
    // low bits are junk while busy so the host cannot lean on them
    wire [7:0]  stat = {busy == 0, busy != 0 ? 7'h2a : {sr[6:1], 1'b1}};
    wire [15:0] val = st_mode ? {stat, stat} : 16'h5a3c;
    wire        rd = !ce_n_i && !oe_n_i;
    assign data_o = rd ? val : ~last;
    assign busy_n_o = busy == 0;
    always @(posedge clk_i) begin
        we_q <= we_n_i;
        if (rd)
            last <= val;
        if (busy > 0)
            busy <= busy - 1;
        if (!reset_n_i) begin
            sr <= 8'h00;
            setup <= 1'b0;
            st_mode <= 1'b0;
            busy <= 0;
        end else if (!we_n_i && we_q && !ce_n_i) begin
            setup <= cmd_i == 16'h6060;
            st_mode <= cmd_i != 16'hffff;
            if (cmd_i == 16'h5050)
                sr <= 8'h00;
            else if (setup && (cmd_i != 16'hd0d0 || mode_i == 2'h2))
                sr[5:4] <= 2'h3;
            else if (setup) begin
                busy <= 20;
                sr <= sr | {2'h0, mode_i == 2'h1, 1'b0, mode_i == 2'h3, 3'h0};
            end
        end
    end
endmodule // lcs_card
`default_nettype wire

// ==== tb_lcs_host.sv ====
// self-checking bench for the lock-clear host sequencer
`timescale 1ns/1ps
`default_nettype none
module tb_lcs_host;
    reg         sys_clk_i = 0, rst_n_i = 0, reg_wr_i = 0, reg_rd_i = 0;
    reg  [3:0]  reg_addr_i = 4'h0;
    reg  [15:0] reg_wdata_i = 16'h0000, got;
    reg  [1:0]  mode = 2'h0;
    wire [15:0] reg_rdata_o, card_data_o, card_data_i;
    wire        card_ce_n_o, card_oe_n_o, card_we_n_o, card_reset_n_o;
    wire        card_data_oe_o, card_busy_n_i;
    integer     err_total = 0, n_tests = 0;
    lcs_host DUT (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
        .reg_rdata_o(reg_rdata_o), .card_ce_n_o(card_ce_n_o), .card_oe_n_o(card_oe_n_o),
        .card_we_n_o(card_we_n_o), .card_reset_n_o(card_reset_n_o),
        .card_data_o(card_data_o), .card_data_oe_o(card_data_oe_o),
        .card_data_i(card_data_i), .card_busy_n_i(card_busy_n_i));
    lcs_card u_card (.clk_i(sys_clk_i), .ce_n_i(card_ce_n_o), .oe_n_i(card_oe_n_o),
        .we_n_i(card_we_n_o), .reset_n_i(card_reset_n_o), .cmd_i(card_data_o),
        .mode_i(mode), .data_o(card_data_i), .busy_n_o(card_busy_n_i));
    initial forever #2.5 sys_clk_i = ~sys_clk_i;
    task close_out;
        begin
            $display("tests %0d errors %0d", n_tests, err_total);
            if (err_total == 0 && n_tests > 0)
                $display("verification passed");
            else
                $display("verification failed");
            $finish;
        end
    endtask
    task cmp(input [15:0] g, input [15:0] e);
        begin
            n_tests = n_tests + 1;
            if (g !== e) begin
                err_total = err_total + 1;
                $display("Error t=%0t got %h exp %h", $time, g, e);
            end
        end
    endtask
    task wr_reg(input [3:0] a, input [15:0] d);
        begin
            reg_addr_i <= a;
            reg_wdata_i <= d;
            reg_wr_i <= 1'b1;
            @(posedge sys_clk_i);
            reg_wr_i <= 1'b0;
        end
    endtask
    task rd_reg(input [3:0] a);
        begin
            reg_addr_i <= a;
            reg_rd_i <= 1'b1;
            @(posedge sys_clk_i);
            reg_rd_i <= 1'b0;
            #1 got = reg_rdata_o;
            @(posedge sys_clk_i);
        end
    endtask
    task run_op(input [1:0] m, input [15:0] c, input [15:0] es, input [15:0] er);
        integer i;
        begin
            mode <= m;
            wr_reg(4'h0, c);
            repeat (2) @(posedge sys_clk_i);
            got = 16'h0001;
            for (i = 0; i < 300 && got[0] !== 1'b0; i = i + 1)
                rd_reg(4'h1);
            cmp(got, es);
            rd_reg(4'h2);
            cmp(got, er);
            cmp({8'h00, u_card.sr}, 16'h0000);
        end
    endtask
    // a few clear operations take well under 8000 cycles
    initial begin
        #40000;
        err_total = err_total + 1;
        close_out;
    end
    initial begin
        repeat (6) @(posedge sys_clk_i);
        rst_n_i <= 1'b1;
        @(posedge sys_clk_i);
        rd_reg(4'h1);
        cmp(got, 16'h0010);
        rd_reg(4'h3);
        cmp(got, 16'h0001);
        rd_reg(4'hf);
        cmp(got, 16'h0000);
        run_op(2'h0, 16'h0001, 16'h0002, 16'h8080);
        run_op(2'h1, 16'h0001, 16'h0006, 16'ha0a0);
        run_op(2'h2, 16'h0001, 16'h000e, 16'hb0b0);
        run_op(2'h3, 16'h0001, 16'h0006, 16'h8888);
        wr_reg(4'h0, 16'h0004);
        repeat (40) @(posedge sys_clk_i);
        cmp({15'h0000, u_card.st_mode}, 16'h0000);
        wr_reg(4'h0, 16'h0002);
        repeat (40) @(posedge sys_clk_i);
        rd_reg(4'h1);
        cmp(got, 16'h0006);
        cmp({15'h0000, u_card.st_mode}, 16'h0001);
        wr_reg(4'h0, 16'h0001);
        repeat (10) @(posedge sys_clk_i);
        rst_n_i <= 1'b0;
        repeat (6) @(posedge sys_clk_i);
        rst_n_i <= 1'b1;
        @(posedge sys_clk_i);
        rd_reg(4'h1);
        cmp(got, 16'h0010);
        close_out;
    end
endmodule // tb_lcs_host
`default_nettype wire
